// ### common/icd_pkg.sv
// Constants of the interval clock and memory channel block.
package icd_pkg;
   // Word bit 0 is the most significant bit, so bit n sits at index 11-n
   localparam logic [11:0] RST_WORD = 12'h000;
   localparam logic [11:0] OP_CLEAR_ALL = 12'hc07;
   localparam logic [8:0] CLK_GROUP = 9'h18b;
   localparam logic [5:0] DMA_GROUP = 6'h32;
   localparam logic [2:0] DMA_REG_DIGIT = 3'h5;
   localparam logic [2:0] DMA_FIELD_DIGIT = 3'h6;
   localparam logic [2:0] CLK_CLEAR_EN = 3'h0;
   localparam logic [2:0] CLK_SKIP = 3'h1;
   localparam logic [2:0] CLK_SET_EN = 3'h2;
   localparam logic [2:0] CLK_LOAD = 3'h3;
   localparam logic [2:0] CLK_READ_EN = 3'h4;
   localparam logic [2:0] CLK_STATUS = 3'h5;
   localparam logic [2:0] CLK_READ_BUF = 3'h6;
   localparam logic [2:0] CLK_READ_CNT = 3'h7;
   localparam logic [2:0] D_LOAD_ADDR = 3'h0;
   localparam logic [2:0] D_READ_ADDR = 3'h1;
   localparam logic [2:0] D_LOAD_COUNT = 3'h2;
   localparam logic [2:0] D_READ_FIELD = 3'h3;
   localparam logic [2:0] D_LOAD_STATUS = 3'h4;
   localparam logic [2:0] D_READ_STATUS = 3'h5;
   localparam logic [2:0] D_SKIP = 3'h6;
   localparam logic [2:0] D_WRITE_VEC = 3'h7;
   localparam int EN_IRQ_BIT = 11;
   localparam int EN_RELOAD_BIT = 9;
   localparam int EN_INHIBIT_BIT = 4;
   localparam logic [11:0] EN_WRITABLE = 12'hbd0;
   localparam int FS_F7E = 6;
   localparam int FS_WOF = 5;
   localparam logic [1:0] MODE_REFRESH = 2'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h1;
   localparam logic [1:0] MODE_BURST = 2'h2;
   localparam logic [1:0] MODE_STOP = 2'h3;
   localparam logic [2:0] RATE_20MS = 3'h2;
   localparam logic [2:0] RATE_2MS = 3'h3;
   localparam logic [2:0] RATE_200US = 3'h4;
   localparam logic [2:0] RATE_20US = 3'h5;
   localparam logic [2:0] RATE_2US = 3'h6;
   localparam logic [2:0] FIELD_TOP = 3'h7;
   localparam logic [11:0] WORD_MAX = 12'hfff;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned T_SRC_NS = 250;
   localparam int unsigned T_20MS_NS = 20000000;
   localparam int unsigned T_2MS_NS = 2000000;
   localparam int unsigned T_200US_NS = 200000;
   localparam int unsigned T_20US_NS = 20000;
   localparam int unsigned T_2US_NS = 2000;
   localparam int unsigned CYC_SRC = T_SRC_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_20MS = T_20MS_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_2MS = T_2MS_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_200US = T_200US_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_20US = T_20US_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_2US = T_2US_NS / CLK_PERIOD_NS;
   localparam int TB_W = 23;
endpackage

// ### common/icd_stream_if.sv
// Valid/ready word stream carrier between block and its FIFO.
interface icd_stream_if #(parameter int WIDTH = 12);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport fifo (input in_valid, input in_data, input out_ready, output in_ready, output out_valid,
      output out_data);
   modport user (output in_valid, output in_data, output out_ready, input in_ready, input out_valid,
      input out_data);
endinterface

// ### logic/icd_fifo.sv
// Flip-flop FIFO holding words of the memory channel data path.
module icd_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   icd_stream_if.fifo s
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] wr_ptr;
   logic [AW:0] fill;
   logic [AW-1:0] next_rd_ptr;
   logic [AW-1:0] next_wr_ptr;
   logic [AW:0] next_fill;
   logic push;
   logic pop;

   assign s.in_ready = (fill != (AW+1)'(DEPTH));
   assign s.out_valid = (fill != '0);
   assign s.out_data = mem[rd_ptr];
   assign push = s.in_valid & s.in_ready;
   assign pop = s.out_valid & s.out_ready;

   always_comb begin
      next_rd_ptr = rd_ptr;
      next_wr_ptr = wr_ptr;
      next_fill = fill;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      if (push && !pop) begin
         next_fill = fill + (AW+1)'(1);
      end else if (pop && !push) begin
         next_fill = fill - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         fill <= '0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         fill <= next_fill;
      end
   end

   // Storage has no reset; words are only read once written
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= s.in_data;
      end
   end
endmodule

// ### logic/icd_timebase.sv
// Programmable tick generator that paces the interval counter.
module icd_timebase #(
   parameter int CNT_W = 23
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [CNT_W-1:0] period,
   output logic tick
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   assign tick = run & (count >= period - CNT_W'(1));

   always_comb begin
      next_count = count + CNT_W'(1);
      if (!run || tick) begin
         next_count = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule

// ### logic/icd_top.sv
// Interval clock and simultaneous memory channel behind I/O-transfer instructions.
module icd_top #(
   parameter int unsigned CYC_20MS = icd_pkg::CYC_20MS,
   parameter int unsigned CYC_2MS = icd_pkg::CYC_2MS,
   parameter int unsigned CYC_200US = icd_pkg::CYC_200US,
   parameter int unsigned CYC_20US = icd_pkg::CYC_20US,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic iot_valid,
   input wire logic [11:0] iot_code,
   input wire logic [11:0] ac_in,
   output logic [11:0] ac_out,
   output logic ac_valid,
   output logic skip,
   output logic irq,
   output logic clock_vector_lsb,
   output logic [10:0] dma_vector,
   output logic [11:0] dma_mode_status,
   output logic dma_req,
   input wire logic dma_ack,
   output logic dma_write,
   output logic dma_refresh,
   output logic [14:0] dma_addr,
   output logic [11:0] dma_wdata,
   input wire logic [11:0] mem_rdata,
   input wire logic port_in_valid,
   output logic port_in_ready,
   input wire logic [11:0] port_in_data,
   output logic port_out_valid,
   input wire logic port_out_ready,
   output logic [11:0] port_out_data
);
   localparam int TW = icd_pkg::TB_W;

   // Instruction decode
   logic caf;
   logic clk_op;
   logic dma_op;
   logic fld_op;
   logic [2:0] fn;

   // Interval clock state
   logic [11:0] clock_rate_and_control;
   logic [11:0] clock_count_value;
   logic [11:0] clock_reload_value;
   logic clock_overflow_flag;
   logic [11:0] next_rate_ctl;
   logic [11:0] next_count;
   logic [11:0] next_reload;
   logic next_cof;
   logic [2:0] rate_code;
   logic tb_run;
   logic [TW-1:0] tb_period;
   logic tick;
   logic clk_ovf;
   logic clock_irq_cond;

   // Memory channel state
   logic [11:0] dma_current_address;
   logic [2:0] dma_field_extension;
   logic [11:0] dma_transfer_length;
   logic top_field_wrap_error;
   logic word_count_overflow_flag;
   logic [1:0] mode_select;
   logic carry_enable;
   logic dma_direction;
   logic dma_irq_enable;
   logic [10:0] vector_reg;
   logic dma_active;
   logic [11:0] next_ca;
   logic [2:0] next_eca;
   logic [11:0] next_wc;
   logic next_f7e;
   logic next_wof;
   logic [1:0] next_mode;
   logic next_ce;
   logic next_dir;
   logic next_ie;
   logic [10:0] next_vec;
   logic next_active;
   logic access;
   logic ca_carry;
   logic wc_ovf;
   logic dma_irq_cond;

   // Instruction answer
   logic [11:0] next_ac;
   logic next_ac_valid;
   logic next_skip;

   icd_stream_if #(.WIDTH(12)) strm ();

   assign caf = iot_valid & (iot_code == icd_pkg::OP_CLEAR_ALL);
   assign clk_op = iot_valid & (iot_code[11:3] == icd_pkg::CLK_GROUP);
   assign dma_op = iot_valid & (iot_code[11:6] == icd_pkg::DMA_GROUP) & (iot_code[2:0] == icd_pkg::DMA_REG_DIGIT);
   assign fld_op = iot_valid & (iot_code[11:6] == icd_pkg::DMA_GROUP)
      & (iot_code[2:0] == icd_pkg::DMA_FIELD_DIGIT);
   assign fn = clk_op ? iot_code[2:0] : iot_code[5:3];

   // Rate select sits in enable bits 3-5, bit 3 most significant
   assign rate_code = clock_rate_and_control[8:6];

   always_comb begin
      tb_run = 1'b1;
      tb_period = TW'(CYC_20MS);
      unique case (rate_code)
         icd_pkg::RATE_20MS: tb_period = TW'(CYC_20MS);
         icd_pkg::RATE_2MS: tb_period = TW'(CYC_2MS);
         icd_pkg::RATE_200US: tb_period = TW'(CYC_200US);
         icd_pkg::RATE_20US: tb_period = TW'(CYC_20US);
         icd_pkg::RATE_2US: tb_period = TW'(icd_pkg::CYC_2US);
         default: tb_run = 1'b0;
      endcase
      // Bypassing the prescaler counts straight at the source rate, for any rate code that runs the clock
      if (clock_rate_and_control[icd_pkg::EN_INHIBIT_BIT]) begin
         tb_period = TW'(icd_pkg::CYC_SRC);
      end
   end

   icd_timebase #(.CNT_W(TW)) u_timebase (
      .clk(clk),
      .rst(rst),
      .run(tb_run),
      .period(tb_period),
      .tick(tick)
   );

   assign clk_ovf = tick & (clock_count_value == icd_pkg::WORD_MAX);
   assign clock_irq_cond = clock_overflow_flag & clock_rate_and_control[icd_pkg::EN_IRQ_BIT];

   // Interval clock next state
   always_comb begin
      next_rate_ctl = clock_rate_and_control;
      next_count = clock_count_value;
      next_reload = clock_reload_value;
      next_cof = clock_overflow_flag;
      if (tick) begin
         next_count = clock_count_value + 12'h001;
      end
      if (clk_ovf && clock_rate_and_control[icd_pkg::EN_RELOAD_BIT]) begin
         next_count = clock_reload_value;
      end
      if (clk_op) begin
         unique case (fn)
            icd_pkg::CLK_CLEAR_EN: next_rate_ctl = clock_rate_and_control
               & ~(ac_in & icd_pkg::EN_WRITABLE);
            icd_pkg::CLK_SET_EN: next_rate_ctl = clock_rate_and_control
               | (ac_in & icd_pkg::EN_WRITABLE);
            icd_pkg::CLK_LOAD: begin
               next_reload = ac_in;
               next_count = ac_in;
            end
            icd_pkg::CLK_STATUS: next_cof = 1'b0;
            icd_pkg::CLK_READ_CNT: next_reload = clock_count_value;
            icd_pkg::CLK_SKIP, icd_pkg::CLK_READ_EN, icd_pkg::CLK_READ_BUF: begin
            end
         endcase
      end
      if (caf) begin
         next_cof = 1'b0;
         next_rate_ctl = icd_pkg::RST_WORD;
         next_reload = icd_pkg::RST_WORD;
      end
      // Overflow in the same cycle as a clear still leaves the flag set
      if (clk_ovf) begin
         next_cof = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clock_rate_and_control <= icd_pkg::RST_WORD;
         clock_count_value <= icd_pkg::RST_WORD;
         clock_reload_value <= icd_pkg::RST_WORD;
         clock_overflow_flag <= 1'b0;
      end else begin
         clock_rate_and_control <= next_rate_ctl;
         clock_count_value <= next_count;
         clock_reload_value <= next_reload;
         clock_overflow_flag <= next_cof;
      end
   end

   // Memory channel data path through the FIFO
   assign strm.in_data = dma_direction ? port_in_data : mem_rdata;
   // A late acknowledge after the last access must not move a word
   assign strm.in_valid = dma_direction ? port_in_valid : access;
   assign strm.out_ready = dma_direction ? access : port_out_ready;
   assign port_in_ready = dma_direction & strm.in_ready;
   assign port_out_valid = ~dma_direction & strm.out_valid;
   assign port_out_data = strm.out_data;
   assign dma_wdata = strm.out_data;

   icd_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .s(strm)
   );

   // Requests wait on FIFO words or space, so the port side throttles the channel
   assign dma_req = dma_active & ((mode_select == icd_pkg::MODE_NORMAL) | (mode_select == icd_pkg::MODE_BURST))
      & (dma_direction ? strm.out_valid : strm.in_ready);
   assign access = dma_req & dma_ack;
   assign ca_carry = dma_current_address == icd_pkg::WORD_MAX;
   assign wc_ovf = access & (dma_transfer_length == icd_pkg::WORD_MAX);
   assign dma_irq_cond = dma_irq_enable & (word_count_overflow_flag | top_field_wrap_error);

   // Memory channel next state
   always_comb begin
      next_ca = dma_current_address;
      next_eca = dma_field_extension;
      next_wc = dma_transfer_length;
      next_f7e = top_field_wrap_error;
      next_wof = word_count_overflow_flag;
      next_mode = mode_select;
      next_ce = carry_enable;
      next_dir = dma_direction;
      next_ie = dma_irq_enable;
      next_vec = vector_reg;
      next_active = dma_active;
      if (access) begin
         next_ca = dma_current_address + 12'h001;
         next_wc = dma_transfer_length + 12'h001;
         if (ca_carry && carry_enable) begin
            next_eca = dma_field_extension + 3'h1;
         end
      end
      if (wc_ovf) begin
         next_active = 1'b0;
         if (mode_select == icd_pkg::MODE_BURST) begin
            next_mode = icd_pkg::MODE_REFRESH;
         end
      end
      if (fld_op) begin
         next_eca = iot_code[5:3];
      end
      if (dma_op) begin
         unique case (fn)
            icd_pkg::D_LOAD_ADDR: next_ca = ac_in;
            icd_pkg::D_LOAD_COUNT: begin
               next_wc = ac_in;
               next_wof = 1'b0;
               next_active = (mode_select != icd_pkg::MODE_STOP);
            end
            icd_pkg::D_LOAD_STATUS: begin
               next_mode = ac_in[4:3];
               next_ce = ac_in[2];
               next_dir = ac_in[1];
               next_ie = ac_in[0];
               next_active = dma_active & (ac_in[4:3] != icd_pkg::MODE_STOP);
            end
            icd_pkg::D_READ_STATUS: next_f7e = 1'b0;
            icd_pkg::D_WRITE_VEC: next_vec = ac_in[11:1];
            icd_pkg::D_READ_ADDR, icd_pkg::D_READ_FIELD, icd_pkg::D_SKIP: begin
            end
         endcase
      end
      if (caf) begin
         next_f7e = 1'b0;
         next_wof = 1'b0;
      end
      // Hardware sets win over any clear landing in the same cycle
      if (access && ca_carry && carry_enable && dma_field_extension == icd_pkg::FIELD_TOP) begin
         next_f7e = 1'b1;
      end
      if (wc_ovf) begin
         next_wof = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_current_address <= icd_pkg::RST_WORD;
         dma_field_extension <= 3'h0;
         dma_transfer_length <= icd_pkg::RST_WORD;
         top_field_wrap_error <= 1'b0;
         word_count_overflow_flag <= 1'b0;
         mode_select <= icd_pkg::MODE_REFRESH;
         carry_enable <= 1'b0;
         dma_direction <= 1'b0;
         dma_irq_enable <= 1'b0;
         vector_reg <= 11'h000;
         dma_active <= 1'b0;
      end else begin
         dma_current_address <= next_ca;
         dma_field_extension <= next_eca;
         dma_transfer_length <= next_wc;
         top_field_wrap_error <= next_f7e;
         word_count_overflow_flag <= next_wof;
         mode_select <= next_mode;
         carry_enable <= next_ce;
         dma_direction <= next_dir;
         dma_irq_enable <= next_ie;
         vector_reg <= next_vec;
         dma_active <= next_active;
      end
   end

   // Status bits 5-11 land in the low seven index positions
   assign dma_mode_status = {5'h00, top_field_wrap_error, word_count_overflow_flag, mode_select, carry_enable,
      dma_direction, dma_irq_enable};

   // Instruction answer: new accumulator value, one cycle after the request
   always_comb begin
      next_ac = ac_in;
      next_ac_valid = iot_valid;
      next_skip = 1'b0;
      if (clk_op) begin
         unique case (fn)
            icd_pkg::CLK_SKIP: next_skip = clock_irq_cond;
            icd_pkg::CLK_READ_EN: next_ac = clock_rate_and_control & icd_pkg::EN_WRITABLE;
            icd_pkg::CLK_STATUS: next_ac = {clock_overflow_flag, 11'h000};
            icd_pkg::CLK_READ_BUF: next_ac = clock_reload_value;
            icd_pkg::CLK_READ_CNT: next_ac = clock_count_value;
            icd_pkg::CLK_CLEAR_EN, icd_pkg::CLK_SET_EN, icd_pkg::CLK_LOAD: next_ac = ac_in;
         endcase
      end
      if (dma_op) begin
         unique case (fn)
            icd_pkg::D_LOAD_ADDR: next_ac = icd_pkg::RST_WORD;
            icd_pkg::D_READ_ADDR: next_ac = dma_current_address;
            icd_pkg::D_LOAD_COUNT: next_ac = icd_pkg::RST_WORD;
            icd_pkg::D_READ_FIELD: next_ac = ac_in | {6'h00, dma_field_extension, 3'h0};
            icd_pkg::D_LOAD_STATUS: next_ac = icd_pkg::RST_WORD;
            icd_pkg::D_READ_STATUS: next_ac = ac_in | dma_mode_status;
            icd_pkg::D_SKIP: next_skip = dma_irq_enable & word_count_overflow_flag;
            icd_pkg::D_WRITE_VEC: next_ac = icd_pkg::RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ac_out <= icd_pkg::RST_WORD;
         ac_valid <= 1'b0;
         skip <= 1'b0;
      end else begin
         ac_out <= next_ac;
         ac_valid <= next_ac_valid;
         skip <= next_skip;
      end
   end

   assign irq = clock_irq_cond | dma_irq_cond;
   assign clock_vector_lsb = ~clock_overflow_flag;
   assign dma_vector = vector_reg;
   assign dma_write = dma_direction;
   assign dma_refresh = (mode_select == icd_pkg::MODE_REFRESH);
   assign dma_addr = {dma_field_extension, dma_current_address};
endmodule

// ### tb/icd_mem_model.sv
// Memory side partner answering channel accesses.
module icd_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic dma_req,
   input wire logic [14:0] dma_addr,
   output logic dma_ack,
   output logic [11:0] mem_rdata,
   output logic [11:0] n_acc
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] junk;
   // Data only means something in the ack cycle, so it churns otherwise
   assign mem_rdata = dma_ack ? (dma_addr[11:0] ^ 12'h5a5) : junk;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_ack <= 1'b0;
         n_acc <= 12'h000;
         junk <= 12'h000;
      end else begin
         // Slow answers never come in two cycles running
         dma_ack <= dma_req && !(slow && dma_ack);
         junk <= junk + 12'h3c7;
         if (dma_req && dma_ack) begin
            n_acc <= n_acc + 12'h001;
         end
      end
   end
endmodule

// ### tb/icd_sva.sv
// Assertions on the instruction and memory channel ports.
module icd_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic iot_valid,
   input wire logic [11:0] iot_code,
   input wire logic [11:0] ac_in,
   input wire logic [11:0] ac_out,
   input wire logic ac_valid,
   input wire logic skip,
   input wire logic irq,
   input wire logic clock_vector_lsb,
   input wire logic [10:0] dma_vector,
   input wire logic [11:0] dma_mode_status,
   input wire logic dma_req,
   input wire logic dma_ack,
   input wire logic [14:0] dma_addr
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_op(logic [11:0] c);
      iot_valid && iot_code == c;
   endsequence
   chk_answer_next: assert property (iot_valid |=> ac_valid) else $error("no answer");
   chk_keep_ac: assert property ((s_op(12'hc58) or s_op(12'hc5a) or s_op(12'hc5b)) |=>
      ac_out == $past(ac_in)) else $error("accumulator changed");
   chk_en_mask: assert property (s_op(12'hc5c) |=> (ac_out & 12'h42f) == 12'h000) else $error("bad en");
   chk_cof_read: assert property (s_op(12'hc5d) |=> ac_out == {~$past(clock_vector_lsb), 11'h000})
      else $error("bad status read");
   chk_vec_write: assert property (s_op(12'hcbd) |=> dma_vector == $past(ac_in[11:1]) && ac_out == 12'h000)
      else $error("bad vector");
   chk_zero_bits: assert property (dma_mode_status[11:7] == 5'h00) else $error("status high bits set");
   chk_idle_modes: assert property (dma_mode_status[4] == dma_mode_status[3] |-> !dma_req)
      else $error("request while idle");
   chk_dma_irq: assert property (dma_mode_status[0] && dma_mode_status[5] |-> irq) else $error("no irq");
   chk_skip_on_count_overflow_skip: assert property (s_op(12'hcb5) |=>
      skip == $past(dma_mode_status[0] && dma_mode_status[5])) else $error("bad skip");
   chk_burst_end: assert property ($rose(dma_mode_status[5]) && $past(dma_mode_status[4:3]) == 2'h2 |->
      dma_mode_status[4:3] == 2'h0) else $error("burst kept");
   chk_addr_step: assert property (dma_req && dma_ack && !iot_valid |=>
      dma_addr[11:0] == $past(dma_addr[11:0]) + 12'h001) else $error("address not stepped");
endmodule
bind icd_top icd_sva icd_sva_inst (.clk, .rst, .iot_valid, .iot_code, .ac_in, .ac_out, .ac_valid, .skip, .irq,
   .clock_vector_lsb, .dma_vector, .dma_mode_status, .dma_req, .dma_ack, .dma_addr);

// ### tb/tb_top.sv
// Self-checking bench for the interval clock and memory channel.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic iot_valid = 1'b0;
   logic [11:0] iot_code = 12'h000;
   logic [11:0] ac_in = 12'h000;
   logic port_out_ready = 1'b0;
   logic port_in_valid = 1'b0;
   logic [11:0] port_in_data = 12'h000;
   logic [11:0] dma_wdata;
   logic port_in_ready, dma_write, dma_refresh;
   logic slow = 1'b1;
   logic [11:0] ac_out, dma_mode_status, port_out_data, mem_rdata, n_acc;
   logic ac_valid, skip, irq, clock_vector_lsb, dma_req, dma_ack, port_out_valid;
   logic [10:0] dma_vector;
   logic [14:0] dma_addr;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int i;
   always #2 clk = ~clk;
   icd_top #(.CYC_20MS(40), .CYC_2MS(30), .CYC_200US(20), .CYC_20US(10)) icd_top_inst (
      .clk, .rst, .iot_valid, .iot_code, .ac_in, .ac_out, .ac_valid, .skip, .irq, .clock_vector_lsb,
      .dma_vector, .dma_mode_status, .dma_req, .dma_ack, .dma_write, .dma_refresh, .dma_addr,
      .dma_wdata, .mem_rdata, .port_in_valid, .port_in_ready, .port_in_data,
      .port_out_valid, .port_out_ready, .port_out_data);
   icd_mem_model icd_mem_model_inst (.clk, .rst, .slow, .dma_req, .dma_addr, .dma_ack, .mem_rdata, .n_acc);
   task automatic stop_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One instruction; the answer stands one cycle after the driving edge
   task automatic iot(input logic [11:0] code, input logic [11:0] ac, input logic [11:0] exp);
      @(posedge clk);
      iot_valid <= 1'b1;
      iot_code <= code;
      ac_in <= ac;
      @(posedge clk);
      iot_valid <= 1'b0;
      #1;
      chk(ac_out, exp);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         stop_test;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      iot(12'hc5c, 12'h000, 12'h000);
      chk(dma_mode_status, 12'h000);
      chk({11'h000, dma_refresh}, 12'h001);
      chk({11'h000, clock_vector_lsb}, 12'h001);
      $display("test reset done");
      iot(12'hc5b, 12'hffe, 12'hffe);
      iot(12'hc5e, 12'h123, 12'hffe);
      iot(12'hc5a, 12'hfff, 12'hfff);
      iot(12'hc5c, 12'h000, 12'hbd0);
      iot(12'hc58, 12'h090, 12'h090);
      iot(12'hc5c, 12'h000, 12'hb40);
      for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
      #1;
      chk({11'h000, irq}, 12'h001);
      chk({11'h000, clock_vector_lsb}, 12'h000);
      iot(12'hc58, 12'h140, 12'h140);
      iot(12'hc59, 12'h000, 12'h000);
      chk({11'h000, skip}, 12'h001);
      iot(12'hc5f, 12'h555, 12'hffe);
      iot(12'hc5d, 12'h555, 12'h800);
      iot(12'hc5d, 12'h555, 12'h000);
      chk({11'h000, irq}, 12'h000);
      // Bypassed prescaler must outlast the 40-cycle rate period
      iot(12'hc58, 12'h200, 12'h200);
      iot(12'hc5b, 12'hfff, 12'hfff);
      iot(12'hc5a, 12'h090, 12'h090);
      for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
      chk({11'h000, i > 50 && i < 70}, 12'h001);
      iot(12'hc5f, 12'h000, 12'h000);
      iot(12'hc07, 12'h000, 12'h000);
      chk({11'h000, clock_vector_lsb}, 12'h001);
      iot(12'hc5c, 12'h000, 12'h000);
      iot(12'hc5e, 12'h000, 12'h000);
      $display("test clock done");
      iot(12'hcbe, 12'h000, 12'h000);
      iot(12'hc85, 12'hffe, 12'h000);
      iot(12'hca5, 12'h00d, 12'h000);
      chk(dma_mode_status, 12'h00d);
      iot(12'hc95, 12'hff6, 12'h000);
      // Sink stalls so the buffer fills and the channel must hold off
      repeat (60) @(posedge clk);
      chk(n_acc, 12'h008);
      port_out_ready <= 1'b1;
      i = 0;
      for (int k = 0; k < 400 && i < 10; k++) begin
         @(negedge clk);
         if (port_out_valid === 1'b1) begin
            chk(port_out_data, (12'hffe + i[11:0]) ^ 12'h5a5);
            i++;
         end
      end
      chk(i[11:0], 12'h00a);
      #1;
      chk(dma_mode_status, 12'h06d);
      iot(12'hcb5, 12'h000, 12'h000);
      chk({11'h000, skip}, 12'h001);
      iot(12'hcad, 12'h000, 12'h06d);
      iot(12'hcad, 12'h000, 12'h02d);
      iot(12'hc8d, 12'h000, 12'h008);
      iot(12'hc9d, 12'h007, 12'h007);
      $display("test normal done");
      slow <= 1'b0;
      iot(12'hca5, 12'h015, 12'h000);
      iot(12'hc95, 12'hfff, 12'h000);
      repeat (20) @(posedge clk);
      #1;
      chk(dma_mode_status, 12'h025);
      iot(12'hca5, 12'h01d, 12'h000);
      iot(12'hc95, 12'hff0, 12'h000);
      repeat (20) @(posedge clk);
      chk(n_acc, 12'h00b);
      iot(12'hcbd, 12'habc, 12'h000);
      chk({1'b0, dma_vector}, 12'h55e);
      $display("test modes done");
      iot(12'hca5, 12'h01a, 12'h000);
      chk({10'h000, dma_write, dma_refresh}, 12'h002);
      chk({11'h000, port_in_ready}, 12'h001);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         port_in_valid <= 1'b1;
         port_in_data <= 12'h100 + 12'(k);
      end
      @(posedge clk);
      port_in_valid <= 1'b0;
      iot(12'hca5, 12'h00b, 12'h000);
      iot(12'hc95, 12'hffd, 12'h000);
      i = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk);
         if (dma_req === 1'b1 && dma_ack === 1'b1) begin
            chk(dma_wdata, 12'h100 + i[11:0]);
            i++;
         end
      end
      chk(n_acc, 12'h00e);
      $display("test write done");
      stop_test;
   end
endmodule
